// ===== twsp_pkg.sv
package twsp_pkg;

   // ==========================================================
   // Addressing and byte framing
   // ==========================================================
   // Seven-bit slave address 1101111
   localparam logic [6:0] TWSP_DEV_ADDR = 7'h6f;
   localparam logic [3:0] TWSP_BITS = 4'h8;
   localparam logic [3:0] TWSP_CNT_ZERO = 4'h0;
   localparam logic [3:0] TWSP_CNT_ONE = 4'h1;
   localparam logic [7:0] TWSP_IDX_STEP = 8'h01;
   localparam logic [7:0] TWSP_BYTE_ZERO = 8'h00;
   localparam logic [1:0] TWSP_PAIR_ZERO = 2'h0;
   localparam logic [2:0] TWSP_SYNC_ZERO = 3'h0;
   localparam logic [2:0] TWSP_PIN_IDLE = 3'h7;

   // ==========================================================
   // Types
   // ==========================================================
   typedef enum logic [2:0] {TWSP_IDLE, TWSP_RX, TWSP_RACK, TWSP_TX, TWSP_TACK} twsp_state_t;
   typedef enum logic [1:0] {TWSP_PH_ADDR, TWSP_PH_IDX, TWSP_PH_DATA} twsp_phase_t;

   typedef struct packed
   {
      logic [7:0] idx;
      logic [7:0] data;
   } twsp_wr_t;

endpackage

// ===== twsp_top.sv
module twsp_top #(
   parameter logic [6:0] DEV_ADDR = twsp_pkg::TWSP_DEV_ADDR,
   parameter int NREG = 16
) (
   // System clock and reset
   input wire logic mclk,
   input wire logic rst,
   // Link clock
   input wire logic lclk,
   // Two-wire pins
   input wire logic scl_i,
   output logic scl_o,
   output logic scl_oe,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe,
   // Register side
   output logic wr_stb,
   output twsp_pkg::twsp_wr_t wr_word,
   output logic [NREG*8-1:0] regs
);
   import twsp_pkg::*;

   function automatic logic in_range(input logic [7:0] i);
      return 32'(i) < NREG;
   endfunction

   // ==========================================================
   // Link domain: reset and pin synchronisers
   // ==========================================================
   logic [1:0] lrst_s_r;
   logic lrst;
   logic [2:0] scl_s_r;
   logic [2:0] sda_s_r;
   logic scl_f_r;
   logic sda_f_r;
   logic scl_n;
   logic sda_n;
   logic scl_rise;
   logic scl_fall;
   logic start_c;
   logic stop_c;

   always_ff @(posedge lclk)
   begin
      lrst_s_r <= {lrst_s_r[0], rst};
   end
   assign lrst = lrst_s_r[1];

   always_ff @(posedge lclk)
   begin
      if (lrst)
      begin
         scl_s_r <= TWSP_PIN_IDLE;
         sda_s_r <= TWSP_PIN_IDLE;
         scl_f_r <= 1'b1;
         sda_f_r <= 1'b1;
      end
      else
      begin
         scl_s_r <= {scl_s_r[1:0], scl_i};
         sda_s_r <= {sda_s_r[1:0], sda_i};
         scl_f_r <= scl_n;
         sda_f_r <= sda_n;
      end
   end

   always_comb
   begin
      // Short glitches never get stages two and three to agree
      scl_n = (scl_s_r[1] == scl_s_r[2]) ? scl_s_r[2] : scl_f_r;
      sda_n = (sda_s_r[1] == sda_s_r[2]) ? sda_s_r[2] : sda_f_r;
      scl_rise = ~scl_f_r & scl_n;
      scl_fall = scl_f_r & ~scl_n;
      start_c = scl_f_r & scl_n & sda_f_r & ~sda_n;
      stop_c = scl_f_r & scl_n & ~sda_f_r & sda_n;
   end

   // ==========================================================
   // Link domain: protocol engine
   // ==========================================================
   twsp_state_t st_r, st_nxt;
   twsp_phase_t ph_r, ph_nxt;
   logic [3:0] cnt_r, cnt_nxt;
   logic [7:0] sh_r, sh_nxt;
   logic [7:0] idx_r, idx_nxt;
   logic rd_r, rd_nxt;
   logic oe_r, oe_nxt;
   logic wtg_r, wtg_nxt;
   twsp_wr_t whold_r, whold_nxt;
   logic rtg_r, rtg_nxt;
   logic [7:0] tbuf_r, tbuf_nxt;
   logic [2:0] ack_s_r;
   logic [7:0] rd_data_r;
   logic rak_r, rak_nxt;

   always_comb
   begin
      st_nxt = st_r;
      ph_nxt = ph_r;
      cnt_nxt = cnt_r;
      sh_nxt = sh_r;
      idx_nxt = idx_r;
      rd_nxt = rd_r;
      oe_nxt = oe_r;
      wtg_nxt = wtg_r;
      whold_nxt = whold_r;
      rtg_nxt = rtg_r;
      tbuf_nxt = tbuf_r;
      // Read word is stable once the returned toggle is seen
      if (ack_s_r[1] ^ ack_s_r[2])
      begin
         tbuf_nxt = rd_data_r;
      end
      if (start_c)
      begin
         st_nxt = TWSP_RX;
         ph_nxt = TWSP_PH_ADDR;
         cnt_nxt = TWSP_CNT_ZERO;
         oe_nxt = 1'b0;
      end
      else if (stop_c)
      begin
         st_nxt = TWSP_IDLE;
         oe_nxt = 1'b0;
      end
      else
      begin
         unique case (st_r)
            TWSP_IDLE:
            begin
               oe_nxt = 1'b0;
            end
            TWSP_RX:
            begin
               if (scl_rise)
               begin
                  sh_nxt = {sh_r[6:0], sda_f_r};
                  cnt_nxt = 4'(cnt_r + TWSP_CNT_ONE);
               end
               else if (scl_fall && cnt_r == TWSP_BITS)
               begin
                  cnt_nxt = TWSP_CNT_ZERO;
                  oe_nxt = 1'b1;
                  st_nxt = TWSP_RACK;
                  unique case (ph_r)
                     TWSP_PH_ADDR:
                     begin
                        if (sh_r[7:1] == DEV_ADDR)
                        begin
                           rd_nxt = sh_r[0];
                           ph_nxt = TWSP_PH_IDX;
                           if (sh_r[0])
                           begin
                              rtg_nxt = ~rtg_r;
                           end
                        end
                        else
                        begin
                           oe_nxt = 1'b0;
                           st_nxt = TWSP_IDLE;
                        end
                     end
                     TWSP_PH_IDX:
                     begin
                        idx_nxt = sh_r;
                        ph_nxt = TWSP_PH_DATA;
                     end
                     default:
                     begin
                        whold_nxt.idx = idx_r;
                        whold_nxt.data = sh_r;
                        wtg_nxt = ~wtg_r;
                        idx_nxt = 8'(idx_r + TWSP_IDX_STEP);
                     end
                  endcase
               end
            end
            TWSP_RACK:
            begin
               // Held low through the whole high time; at the fall released, or set to data bit 7 on a read
               if (scl_fall)
               begin
                  if (rd_r)
                  begin
                     st_nxt = TWSP_TX;
                     sh_nxt = tbuf_r;
                     oe_nxt = ~tbuf_r[7];
                     cnt_nxt = TWSP_CNT_ONE;
                  end
                  else
                  begin
                     st_nxt = TWSP_RX;
                     oe_nxt = 1'b0;
                  end
               end
            end
            TWSP_TX:
            begin
               if (scl_fall)
               begin
                  if (cnt_r == TWSP_BITS)
                  begin
                     oe_nxt = 1'b0;
                     st_nxt = TWSP_TACK;
                  end
                  else
                  begin
                     sh_nxt = {sh_r[6:0], 1'b0};
                     oe_nxt = ~sh_r[6];
                     cnt_nxt = 4'(cnt_r + TWSP_CNT_ONE);
                  end
               end
            end
            TWSP_TACK:
            begin
               if (scl_rise)
               begin
                  if (sda_f_r)
                  begin
                     st_nxt = TWSP_IDLE;
                  end
                  else
                  begin
                     idx_nxt = 8'(idx_r + TWSP_IDX_STEP);
                     rtg_nxt = ~rtg_r;
                  end
               end
               else if (scl_fall)
               begin
                  st_nxt = TWSP_TX;
                  sh_nxt = tbuf_r;
                  oe_nxt = ~tbuf_r[7];
                  cnt_nxt = TWSP_CNT_ONE;
               end
            end
         endcase
      end
   end

   always_ff @(posedge lclk)
   begin
      if (lrst)
      begin
         st_r <= TWSP_IDLE;
         ph_r <= TWSP_PH_ADDR;
         cnt_r <= TWSP_CNT_ZERO;
         sh_r <= TWSP_BYTE_ZERO;
         idx_r <= TWSP_BYTE_ZERO;
         rd_r <= 1'b0;
         oe_r <= 1'b0;
         wtg_r <= 1'b0;
         whold_r <= '0;
         rtg_r <= 1'b0;
         tbuf_r <= TWSP_BYTE_ZERO;
         ack_s_r <= TWSP_SYNC_ZERO;
      end
      else
      begin
         st_r <= st_nxt;
         ph_r <= ph_nxt;
         cnt_r <= cnt_nxt;
         sh_r <= sh_nxt;
         idx_r <= idx_nxt;
         rd_r <= rd_nxt;
         oe_r <= oe_nxt;
         wtg_r <= wtg_nxt;
         whold_r <= whold_nxt;
         rtg_r <= rtg_nxt;
         tbuf_r <= tbuf_nxt;
         ack_s_r <= {ack_s_r[1:0], rak_r};
      end
   end

   // ==========================================================
   // Pin drivers: open drain only, clock never stretched
   // ==========================================================
   logic [1:0] pin_lo_r;

   always_ff @(posedge lclk)
   begin
      pin_lo_r <= TWSP_PAIR_ZERO;
   end
   assign sda_oe = oe_r;
   assign sda_o = pin_lo_r[0];
   assign scl_o = pin_lo_r[1];
   assign scl_oe = pin_lo_r[0];

   // ==========================================================
   // System domain: register bank and crossings
   // ==========================================================
   logic [2:0] wr_s_r;
   logic [2:0] rq_s_r;
   logic [7:0] bank_r [NREG];
   logic [7:0] bank_nxt [NREG];
   logic [7:0] rd_data_nxt;
   logic wr_stb_r, wr_stb_nxt;
   twsp_wr_t wr_word_r, wr_word_nxt;

   always_comb
   begin
      bank_nxt = bank_r;
      rak_nxt = rak_r;
      rd_data_nxt = rd_data_r;
      wr_stb_nxt = 1'b0;
      wr_word_nxt = wr_word_r;
      // Held word was stable long before its toggle arrived
      if (wr_s_r[1] ^ wr_s_r[2])
      begin
         wr_stb_nxt = 1'b1;
         wr_word_nxt = whold_r;
         if (in_range(whold_r.idx))
         begin
            bank_nxt[whold_r.idx[$clog2(NREG)-1:0]] = whold_r.data;
         end
      end
      if (rq_s_r[1] ^ rq_s_r[2])
      begin
         rak_nxt = ~rak_r;
         rd_data_nxt = in_range(idx_r) ? bank_r[idx_r[$clog2(NREG)-1:0]] : TWSP_BYTE_ZERO;
      end
   end

   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         wr_s_r <= TWSP_SYNC_ZERO;
         rq_s_r <= TWSP_SYNC_ZERO;
         bank_r <= '{default: TWSP_BYTE_ZERO};
         rak_r <= 1'b0;
         rd_data_r <= TWSP_BYTE_ZERO;
         wr_stb_r <= 1'b0;
         wr_word_r <= '0;
      end
      else
      begin
         wr_s_r <= {wr_s_r[1:0], wtg_r};
         rq_s_r <= {rq_s_r[1:0], rtg_r};
         bank_r <= bank_nxt;
         rak_r <= rak_nxt;
         rd_data_r <= rd_data_nxt;
         wr_stb_r <= wr_stb_nxt;
         wr_word_r <= wr_word_nxt;
      end
   end

   assign wr_stb = wr_stb_r;
   assign wr_word = wr_word_r;

   genvar gi;
   generate
      for (gi = 0; gi < NREG; gi++)
      begin : g_regs
         assign regs[gi*8 +: 8] = bank_r[gi];
      end
   endgenerate

endmodule

// ===== twsp_chk_sva.sv
module twsp_chk
   import twsp_pkg::*;
#(
   parameter int NREG = 16
) (
   // Clocks and reset
   input wire logic mclk,
   input wire logic rst,
   input wire logic lclk,
   // Two-wire pins
   input wire logic scl_i,
   input wire logic scl_o,
   input wire logic scl_oe,
   input wire logic sda_i,
   input wire logic sda_o,
   input wire logic sda_oe,
   // Register side
   input wire logic wr_stb,
   input twsp_pkg::twsp_wr_t wr_word,
   input wire logic [NREG*8-1:0] regs
);
   timeunit 1ns;
   timeprecision 1ns;
   // =====
   // Pins
   chk_scl_released: assert property (@(posedge lclk) disable iff (rst) !scl_oe)
      else $error("clock pin driven");
   chk_sda_pull_only: assert property (@(posedge lclk) disable iff (rst) sda_oe |-> !sda_o)
      else $error("data pin driven high");
   // Raw pin is fine here: the filter lags the pin by several link cycles
   chk_sda_moves_low: assert property (@(posedge lclk) disable iff (rst)
      $changed(sda_oe) |-> !scl_i && !$past(scl_i))
      else $error("data pin moved during clock high");
   chk_ack_spans_high: assert property (@(posedge lclk) disable iff (rst)
      $rose(scl_i) && sda_oe |=> sda_oe)
      else $error("pull released in clock high");
   // =====
   // Register side
   chk_stb_single: assert property (@(posedge mclk) disable iff (rst) wr_stb |=> !wr_stb)
      else $error("strobe longer than one cycle");
   chk_word_moves: assert property (@(posedge mclk) disable iff (rst) $changed(wr_word) |-> wr_stb)
      else $error("write word changed without strobe");
   chk_bank_moves: assert property (@(posedge mclk) disable iff (rst) $changed(regs) |-> wr_stb)
      else $error("bank changed without strobe");
   chk_bank_store: assert property (@(posedge mclk) disable iff (rst)
      wr_stb && (wr_word.idx < NREG) |-> regs[8*wr_word.idx +: 8] == wr_word.data)
      else $error("bank byte differs from written data");
   cover property (@(posedge mclk) wr_stb);
   cover property (@(posedge lclk) $rose(sda_oe));
   cover property (@(posedge mclk) wr_stb && wr_word.idx == 8'h07);
endmodule

bind twsp_top twsp_chk #(.NREG(NREG)) i_twsp_chk (.mclk(mclk), .rst(rst), .lclk(lclk), .scl_i(scl_i),
   .scl_o(scl_o), .scl_oe(scl_oe), .sda_i(sda_i), .sda_o(sda_o), .sda_oe(sda_oe), .wr_stb(wr_stb),
   .wr_word(wr_word), .regs(regs));

// ===== twsp_mst.sv
module twsp_mst (
   // Pacing clock
   input wire logic mclk,
   // Resolved data wire
   input wire logic sda_w,
   // Open-drain releases, 1 = released
   output logic scl_m,
   output logic sda_m
);
   timeunit 1ns;
   timeprecision 1ns;
   initial
   begin
      scl_m = 1'b1;
      sda_m = 1'b1;
   end
   // =====
   // One third of a bit period; slow so the link filters keep up
   task automatic drv(input logic c, input logic d);
      scl_m <= c;
      sda_m <= d;
      repeat (16) @(posedge mclk);
   endtask
   task automatic start();
      drv(1'b0, 1'b1);
      drv(1'b1, 1'b1);
      drv(1'b1, 1'b0);
      drv(1'b0, 1'b0);
   endtask
   task automatic stop();
      drv(1'b0, 1'b0);
      drv(1'b1, 1'b0);
      drv(1'b1, 1'b1);
   endtask
   task automatic bitx(input logic b, output logic r);
      drv(1'b0, b);
      drv(1'b1, b);
      r = sda_w;
      drv(1'b0, b);
   endtask
   // Sends tx, releases for the ack slot when ak_in is high
   task automatic xfer(input logic [7:0] tx, input logic ak_in, output logic [7:0] rx, output logic ak);
      logic r;
      for (int i = 7; i >= 0; i--)
      begin
         bitx(tx[i], r);
         rx[i] = r;
      end
      bitx(ak_in, r);
      ak = ~r;
   endtask
endmodule

// ===== testbench.sv
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin fail_count++; $display("ERROR %0t got %h want %h", $time, a, b); end end
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   import twsp_pkg::*;
   logic mclk = 1'b0;
   logic lclk = 1'b0;
   logic rst = 1'b1;
   logic scl_o, scl_oe, sda_o, sda_oe, wr_stb, scl_m, sda_m;
   twsp_wr_t wr_word;
   logic [127:0] regs;
   int fail_count = 0;
   int compares = 0;
   int stb_n = 0;
   // Open drain: any party pulling low wins
   wire scl_w = scl_m & (scl_oe ? scl_o : 1'b1);
   wire sda_w = sda_m & (sda_oe ? sda_o : 1'b1);
   always #20 mclk = ~mclk;
   always #32 lclk = ~lclk;
   always @(posedge mclk) if (wr_stb === 1'b1) stb_n++;
   twsp_top i_twsp_top (.mclk(mclk), .rst(rst), .lclk(lclk), .scl_i(scl_w), .scl_o(scl_o), .scl_oe(scl_oe),
      .sda_i(sda_w), .sda_o(sda_o), .sda_oe(sda_oe), .wr_stb(wr_stb), .wr_word(wr_word), .regs(regs));
   twsp_mst i_twsp_mst (.mclk(mclk), .sda_w(sda_w), .scl_m(scl_m), .sda_m(sda_m));
   // =====
   // Helpers
   task automatic stop_test();
      if (fail_count == 0 && compares > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic wb(input logic [7:0] b, input logic exp);
      logic [7:0] rx;
      logic ak;
      i_twsp_mst.xfer(b, 1'b1, rx, ak);
      `CHK(ak, exp)
   endtask
   // =====
   // Scenarios
   task automatic t_reset();
      `CHK(regs, 128'h0)
      `CHK(sda_oe, 1'b0)
      `CHK(scl_oe, 1'b0)
      `CHK(sda_o, 1'b0)
      `CHK(scl_o, 1'b0)
   endtask
   task automatic t_write();
      int s;
      s = stb_n;
      i_twsp_mst.start();
      wb(8'hde, 1'b1);
      wb(8'h03, 1'b1);
      wb(8'ha5, 1'b1);
      wb(8'h3c, 1'b1);
      i_twsp_mst.stop();
      `CHK(stb_n - s, 2)
      `CHK(regs[31:24], 8'ha5)
      `CHK(regs[39:32], 8'h3c)
      `CHK(wr_word, 16'h043c)
   endtask
   task automatic t_read();
      logic [7:0] rx;
      logic ak;
      int s;
      s = stb_n;
      i_twsp_mst.start();
      wb(8'hde, 1'b1);
      wb(8'h03, 1'b1);
      i_twsp_mst.stop();
      i_twsp_mst.start();
      wb(8'hdf, 1'b1);
      i_twsp_mst.xfer(8'hff, 1'b0, rx, ak);
      `CHK(rx, 8'ha5)
      i_twsp_mst.xfer(8'hff, 1'b1, rx, ak);
      `CHK(rx, 8'h3c)
      i_twsp_mst.stop();
      `CHK(stb_n - s, 0)
   endtask
   task automatic t_bad();
      int s;
      s = stb_n;
      i_twsp_mst.start();
      wb(8'ha0, 1'b0);
      wb(8'h03, 1'b0);
      wb(8'h77, 1'b0);
      i_twsp_mst.stop();
      `CHK(stb_n - s, 0)
      `CHK(regs[31:24], 8'ha5)
      // Index past the bank: strobe still pulses, bank left alone
      i_twsp_mst.start();
      wb(8'hde, 1'b1);
      wb(8'h20, 1'b1);
      wb(8'h55, 1'b1);
      i_twsp_mst.stop();
      `CHK(stb_n - s, 1)
      `CHK(wr_word, 16'h2055)
      `CHK(regs[31:24], 8'ha5)
   endtask
   task automatic t_abort();
      logic r;
      i_twsp_mst.start();
      wb(8'hde, 1'b1);
      wb(8'h05, 1'b1);
      repeat (4) i_twsp_mst.bitx(1'b1, r);
      i_twsp_mst.stop();
      `CHK(regs[47:40], 8'h00)
      i_twsp_mst.start();
      wb(8'hde, 1'b1);
      wb(8'h06, 1'b1);
      i_twsp_mst.stop();
      i_twsp_mst.start();
      wb(8'hde, 1'b1);
      wb(8'h07, 1'b1);
      wb(8'h11, 1'b1);
      i_twsp_mst.stop();
      `CHK(regs[55:48], 8'h00)
      `CHK(regs[63:56], 8'h11)
   endtask
   // =====
   // Main sequence and watchdog
   initial
   begin
      repeat (16) @(posedge mclk);
      rst <= 1'b0;
      repeat (8) @(posedge mclk);
      t_reset();
      t_write();
      t_read();
      t_bad();
      t_abort();
      stop_test();
   end
   initial
   begin
      repeat (100000) @(posedge mclk);
      fail_count++;
      stop_test();
   end
endmodule
